// File: ops_map.svh
`ifndef OPS_MAP_SVH
`define OPS_MAP_SVH

// register byte offsets on the AXI4-Lite slave
`define REG_WACC 8'h00
`define REG_BANK 8'h04
`define REG_STAT 8'h08
`define REG_TPTR 8'h0C
`define REG_TLAT 8'h10
`define REG_INFO 8'h14

// instruction word field positions
`define BIT_A 8
`define BIT_D 9
`define BIT_S_RET 0
`define BIT_S_CALL 8
`define BIDX_HI 11
`define BIDX_LO 9
`define TBL_WR 2

// second word of a double-word instruction
`define WORD2_TAG 4'hF

// fixed banks of the access region
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF

// reset values
`define RST_WACC 8'h00
`define RST_BANK 4'h0
`define RST_STAT 5'h00
`define RST_TPTR 21'h000000
`define RST_TLAT 8'h00

// oscillator periods per instruction cycle
`define OSC_PER_CYCLE 4

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: ops_pkg.sv
package ops_pkg;

  // instruction format, supplied by the fetch stage
  typedef enum logic [3:0] {
    FMT_NONE = 4'h0,
    FMT_BYTE = 4'h1,
    FMT_BIT = 4'h2,
    FMT_LIT8 = 4'h3,
    FMT_LFSR = 4'h4,
    FMT_MOVFF = 4'h5,
    FMT_BRA11 = 4'h6,
    FMT_BRA8 = 4'h7,
    FMT_GOTO = 4'h8,
    FMT_CALL = 4'h9,
    FMT_RET = 4'hA,
    FMT_TBL = 4'hB,
    FMT_IDX = 4'hC
  } fmt_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_IOR = 3'h3,
    ALU_XOR = 3'h4,
    ALU_MOV = 3'h5
  } alu_op_e;

  typedef enum logic [1:0] {
    TBL_KEEP = 2'h0,
    TBL_POST_INC = 2'h1,
    TBL_POST_DEC = 2'h2,
    TBL_PRE_INC = 2'h3
  } tbl_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } dec_state_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_s;

  typedef struct packed {
    logic valid;
    fmt_e fmt;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic to_wacc;
    logic [2:0] bit_index;
    logic [7:0] bit_mask;
    logic [1:0] ptr_sel;
    logic [19:0] literal;
    logic [20:0] branch;
    logic rel;
    logic fast;
    tbl_mode_e tbl_mode;
  } decode_s;

endpackage : ops_pkg

// File: alu_flags.sv
`timescale 1ns/1ps
module alu_flags (
  input ops_pkg::alu_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] result,
  output ops_pkg::flags_s flags,
  output ops_pkg::flags_s upd
);
  import ops_pkg::*;

  // a is the file operand, b the accumulator
  always_comb begin
    logic [8:0] sum;
    logic [4:0] half;
    sum = 9'h000;
    half = 5'h00;
    flags = '0;
    upd = '0;
    case (op)
      ALU_ADD: begin
        sum = {1'b0, a} + {1'b0, b};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        flags.ov = (a[7] == b[7]) && (sum[7] != a[7]);
        upd = '1;
      end
      ALU_SUB: begin
        // carry reads as not-borrow
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        flags.ov = (a[7] != b[7]) && (sum[7] != a[7]);
        upd = '1;
      end
      ALU_AND: sum = {1'b0, a & b};
      ALU_IOR: sum = {1'b0, a | b};
      ALU_XOR: sum = {1'b0, a ^ b};
      ALU_MOV: sum = {1'b0, a};
      default: sum = 9'h000;
    endcase
    result = sum[7:0];
    flags.c = sum[8];
    flags.dc = half[4];
    flags.z = (sum[7:0] == 8'h00);
    flags.n = sum[7];
    // logic and move ops touch only zero and negative
    upd.z = 1'b1;
    upd.n = 1'b1;
  end

endmodule : alu_flags

// File: fast_shadow.sv
`timescale 1ns/1ps
`include "ops_map.svh"
module fast_shadow (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic capture,
  input wire logic [7:0] wacc_in,
  input ops_pkg::flags_s flags_in,
  input wire logic [3:0] bank_in,
  output logic [7:0] wacc,
  output ops_pkg::flags_s flags,
  output logic [3:0] bank
);
  import ops_pkg::*;

  // one shadow slot; a second capture overwrites the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wacc <= `RST_WACC;
      flags <= flags_s'(`RST_STAT);
      bank <= `RST_BANK;
    end else if (capture) begin
      wacc <= wacc_in;
      flags <= flags_in;
      bank <= bank_in;
    end
  end

endmodule : fast_shadow

// File: operand_field_decoder.sv
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ops_map.svh"
// Summary of operation
// - With a=0 the access region is addressed and the bank register ignored, with a=1 it banks.
// - The three-bit bit index picks one of bits 0 to 7 of the addressed byte.
// - With d=0 the result goes to the working accumulator instead of the file register.
// - The file field is an 8-bit address or, for pointer loads, a 2-bit pointer designator.
// - The two-word move takes a 12-bit source and a separate 12-bit destination address.
// - Literals are extracted as 8, 12 or 20 bits depending on the format.
// - Branch fields are signed displacements when relative and absolute targets otherwise.
// - Table mode selects keep, post-increment, post-decrement or pre-increment.
// - The table pointer is 21 bits and table data moves through an 8-bit table latch.
// - Fast call or return with s=1 saves or restores via shadows, s=0 leaves them alone.
// - Indexed forms add 7-bit source and destination offsets to the indirect pointer.
// - Carry, digit carry, zero, signed wrap and negative flags are kept and updated.
// - Don't-care bits never influence decoding.
// - With d=1 the result is written back to the addressed file register.
// - A second word with its top four bits set, met on its own, acts as a no-operation.
// - An instruction that changes the program counter adds one no-operation cycle.
module operand_field_decoder #(
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input ops_pkg::fmt_e fetch_format,
  input ops_pkg::alu_op_e alu_op,
  input wire logic [7:0] file_rdata,
  input wire logic [11:0] ind_base,
  input wire logic [7:0] tbl_rdata,
  input wire logic irq_entry,
  output ops_pkg::decode_s dec,
  output logic file_we,
  output logic [11:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic [20:0] tbl_addr,
  output logic tbl_rd,
  output logic tbl_wr,
  output logic [7:0] tbl_wdata,
  output logic flush
);
  import ops_pkg::*;

  dec_state_e state;
  fmt_e held_fmt;
  logic [15:0] held;
  decode_s nd;
  logic first_ok;
  logic second_ok;
  logic pc_change;
  logic [3:0] bank_used;
  logic [11:0] faddr;
  logic [7:0] bit_sel;
  logic [7:0] wacc;
  logic [3:0] bank;
  flags_s flags;
  logic [20:0] tptr;
  logic [7:0] tlat;
  logic [7:0] alu_res;
  flags_s alu_f;
  flags_s alu_upd;
  logic [7:0] sh_wacc;
  flags_s sh_flags;
  logic [3:0] sh_bank;
  logic byte_done;
  logic tbl_done;
  logic call_fast;
  logic ret_fast;
  tbl_mode_e tmode;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] tptr_merge;
  logic [31:0] rd_mux;
  logic rd_hit;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    lanes = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) lanes[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction : lanes

  always_comb begin
    if (fetch_word[`BIT_A]) begin
      bank_used = bank;
    end else if (fetch_word[7:0] < ACCESS_SPLIT) begin
      bank_used = `ACCESS_LO_BANK;
    end else begin
      bank_used = `ACCESS_HI_BANK;
    end
  end
  assign faddr = {bank_used, fetch_word[7:0]};

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign bit_sel[i] = (fetch_word[`BIDX_HI:`BIDX_LO] == 3'(i));
  end

  // a lone second word falls through as a no-operation
  assign first_ok = fetch_valid && (state == ST_IDLE) && (fetch_word[15:12] != `WORD2_TAG);
  assign second_ok = fetch_valid && (state == ST_SECOND) && (fetch_word[15:12] == `WORD2_TAG);

  // field extraction; unused bits are never looked at
  // don't-care bits ignored
  always_comb begin
    nd = '0;
    pc_change = 1'b0;
    if (first_ok) begin
      nd.fmt = fetch_format;
      case (fetch_format)
        FMT_BYTE: begin
          nd.valid = 1'b1;
          nd.src_addr = faddr;
          nd.to_wacc = !fetch_word[`BIT_D];
          nd.dst_addr = fetch_word[`BIT_D] ? faddr : 12'h000;
        end
        FMT_BIT: begin
          nd.valid = 1'b1;
          nd.src_addr = faddr;
          nd.dst_addr = faddr;
          nd.bit_index = fetch_word[`BIDX_HI:`BIDX_LO];
          nd.bit_mask = bit_sel;
        end
        FMT_LIT8: begin
          nd.valid = 1'b1;
          nd.literal = {12'h000, fetch_word[7:0]};
        end
        FMT_BRA11: begin
          nd.valid = 1'b1;
          nd.rel = 1'b1;
          nd.branch = {{10{fetch_word[10]}}, fetch_word[10:0]};
          pc_change = 1'b1;
        end
        FMT_BRA8: begin
          nd.valid = 1'b1;
          nd.rel = 1'b1;
          nd.branch = {{13{fetch_word[7]}}, fetch_word[7:0]};
          pc_change = 1'b1;
        end
        FMT_RET: begin
          nd.valid = 1'b1;
          nd.fast = fetch_word[`BIT_S_RET];
          pc_change = 1'b1;
        end
        FMT_TBL: begin
          nd.valid = 1'b1;
          nd.tbl_mode = tbl_mode_e'(fetch_word[1:0]);
        end
        default: nd.fmt = fetch_format;
      endcase
    end else if (second_ok) begin
      nd.fmt = held_fmt;
      nd.valid = 1'b1;
      case (held_fmt)
        FMT_MOVFF: begin
          nd.src_addr = held[11:0];
          nd.dst_addr = fetch_word[11:0];
        end
        FMT_LFSR: begin
          nd.ptr_sel = held[5:4];
          nd.literal = {8'h00, held[3:0], fetch_word[7:0]};
        end
        FMT_GOTO, FMT_CALL: begin
          nd.literal = {fetch_word[11:0], held[7:0]};
          nd.branch = {1'b0, fetch_word[11:0], held[7:0]};
          nd.fast = (held_fmt == FMT_CALL) && held[`BIT_S_CALL];
          pc_change = 1'b1;
        end
        FMT_IDX: begin
          nd.src_addr = ind_base + {5'h00, held[6:0]};
          nd.dst_addr = ind_base + {5'h00, fetch_word[6:0]};
        end
        default: nd.valid = 1'b0;
      endcase
    end
  end

  // two-word sequencing; a non-tagged word while waiting aborts the pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      held <= 16'h0000;
      held_fmt <= FMT_NONE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (first_ok && (fetch_format inside {FMT_MOVFF, FMT_LFSR, FMT_GOTO,
                                                FMT_CALL, FMT_IDX})) begin
            state <= ST_SECOND;
            held <= fetch_word;
            held_fmt <= fetch_format;
          end
        end
        ST_SECOND: begin
          if (fetch_valid) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // decoded fields and the extra cycle after a jump
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec <= '0;
      flush <= 1'b0;
    end else begin
      dec <= nd;
      flush <= pc_change;
    end
  end

  alu_flags u_alu (
    .op(alu_op),
    .a(file_rdata),
    .b(wacc),
    .result(alu_res),
    .flags(alu_f),
    .upd(alu_upd)
  );

  assign byte_done = first_ok && (fetch_format == FMT_BYTE);
  assign tbl_done = first_ok && (fetch_format == FMT_TBL);
  assign call_fast = second_ok && (held_fmt == FMT_CALL) && held[`BIT_S_CALL];
  assign ret_fast = first_ok && (fetch_format == FMT_RET) && fetch_word[`BIT_S_RET];
  assign tmode = tbl_mode_e'(fetch_word[1:0]);

  // shadow captured on a fast call or on irq_entry
  fast_shadow u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .capture(call_fast || irq_entry),
    .wacc_in(wacc),
    .flags_in(flags),
    .bank_in(bank),
    .wacc(sh_wacc),
    .flags(sh_flags),
    .bank(sh_bank)
  );

  // accumulator: restore beats result beats software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wacc <= `RST_WACC;
    end else if (ret_fast) begin
      wacc <= sh_wacc;
    end else if (byte_done && !fetch_word[`BIT_D]) begin
      wacc <= alu_res;
    end else if (wr_fire && aw_addr == `REG_WACC && w_strb[0]) begin
      wacc <= w_data[7:0];
    end
  end

  // write back to the file register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_we <= 1'b0;
      file_waddr <= 12'h000;
      file_wdata <= 8'h00;
    end else begin
      file_we <= byte_done && fetch_word[`BIT_D];
      file_waddr <= faddr;
      file_wdata <= alu_res;
    end
  end

  // bank register steers the RAM address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank <= `RST_BANK;
    end else if (ret_fast) begin
      bank <= sh_bank;
    end else if (wr_fire && aw_addr == `REG_BANK && w_strb[0]) begin
      bank <= w_data[3:0];
    end
  end

  // status flags; hardware update wins over a same-cycle write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= flags_s'(`RST_STAT);
    end else if (ret_fast) begin
      flags <= sh_flags;
    end else if (byte_done) begin
      flags <= flags_s'((flags & ~alu_upd) | (alu_f & alu_upd));
    end else if (wr_fire && aw_addr == `REG_STAT && w_strb[0]) begin
      flags <= flags_s'(w_data[4:0]);
    end
  end

  assign tptr_merge = lanes({11'h000, tptr}, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tptr <= `RST_TPTR;
      tlat <= `RST_TLAT;
      tbl_addr <= `RST_TPTR;
      tbl_rd <= 1'b0;
      tbl_wr <= 1'b0;
      tbl_wdata <= `RST_TLAT;
    end else begin
      tbl_rd <= tbl_done && !fetch_word[`TBL_WR];
      tbl_wr <= tbl_done && fetch_word[`TBL_WR];
      tbl_wdata <= tlat;
      if (tbl_rd) tlat <= tbl_rdata;
      else if (wr_fire && aw_addr == `REG_TLAT && w_strb[0]) tlat <= w_data[7:0];
      if (tbl_done) begin
        tbl_addr <= (tmode == TBL_PRE_INC) ? tptr + 21'h000001 : tptr;
        case (tmode)
          TBL_POST_INC, TBL_PRE_INC: tptr <= tptr + 21'h000001;
          TBL_POST_DEC: tptr <= tptr - 21'h000001;
          default: tptr <= tptr;
        endcase
      end else if (wr_fire && aw_addr == `REG_TPTR) begin
        tptr <= tptr_merge[20:0];
      end
    end
  end

  // bus write channels, address and data in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // info register is read-only
        s_axi_bresp <= (aw_addr <= `REG_TLAT) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; info shows the sequencer state
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `REG_WACC: rd_mux = {24'h000000, wacc};
      `REG_BANK: rd_mux = {28'h0000000, bank};
      `REG_STAT: rd_mux = {27'h0000000, flags};
      `REG_TPTR: rd_mux = {11'h000, tptr};
      `REG_TLAT: rd_mux = {24'h000000, tlat};
      `REG_INFO: rd_mux = {30'h00000000, state};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : operand_field_decoder

// File: operand_field_decoder_asserts.sv
`timescale 1ns/1ps
module operand_field_decoder_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] fetch_word,
  input ops_pkg::decode_s dec,
  input wire logic file_we,
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic flush
);
  import ops_pkg::*;
  logic [15:0] word_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // word seen at the previous edge, the one a decode result belongs to
  always_ff @(posedge aclk) begin
    word_q <= fetch_word;
  end
  // bus steps: request taken, then answer with the channel refusing more
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not withdrawn");
  a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn");
  a_dest_select: assert property (
    dec.valid && dec.fmt == FMT_BYTE |-> file_we == !dec.to_wacc)
    else $error("destination select wrong");
  a_bit_mask: assert property (
    dec.valid && dec.fmt == FMT_BIT |-> dec.bit_index == word_q[11:9]
      && dec.bit_mask == (8'h01 << dec.bit_index))
    else $error("bit mask wrong");
  a_table_strobe: assert property (
    dec.valid && dec.fmt == FMT_TBL |-> tbl_wr == word_q[2] && tbl_rd == !word_q[2])
    else $error("table strobe wrong");
  a_jump_flush: assert property (
    dec.valid && dec.fmt inside {FMT_GOTO, FMT_CALL, FMT_BRA11, FMT_RET} |-> flush)
    else $error("flush missing after jump");
  a_rel_branch: assert property (
    dec.valid && dec.fmt == FMT_BRA11 |-> dec.rel
      && dec.branch == {{10{word_q[10]}}, word_q[10:0]})
    else $error("relative branch wrong");
endmodule : operand_field_decoder_asserts

bind operand_field_decoder operand_field_decoder_asserts u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .fetch_word, .dec, .file_we, .tbl_rd, .tbl_wr, .flush
);

// File: core_mem_model.sv
`timescale 1ns/1ps
module core_mem_model (
  input wire logic aclk,
  input wire logic [15:0] fetch_word,
  input wire logic file_we,
  input wire logic [11:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic [20:0] tbl_addr,
  input wire logic tbl_rd,
  output logic [7:0] file_rdata,
  output logic [7:0] tbl_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;
  // file bytes preset to their own index
  initial begin
    last = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  assign file_rdata = mem[fetch_word[7:0]];
  // writes land at the edge, so a same-cycle read still sees old data
  always @(posedge aclk) begin
    if (file_we) begin
      mem[file_waddr[7:0]] <= file_wdata;
    end
    last <= tbl_rdata;
  end
  // 8-bit table data
  // no strobe: inverse of the last value, never a stale copy
  assign tbl_rdata = tbl_rd ? (tbl_addr[7:0] ^ 8'hA5) : ~last;
endmodule : core_mem_model

// File: operand_field_decoder_tb_top.sv
`timescale 1ns/1ps
`include "ops_map.svh"
module operand_field_decoder_tb_top;
  import ops_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, file_rdata, tbl_rdata, file_wdata, tbl_wdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic fetch_valid, irq_entry, file_we, tbl_rd, tbl_wr, flush;
  logic [15:0] fetch_word;
  logic [11:0] ind_base, file_waddr;
  logic [20:0] tbl_addr;
  fmt_e fetch_format;
  alu_op_e alu_op;
  decode_s dec;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  operand_field_decoder uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .fetch_valid, .fetch_word, .fetch_format, .alu_op, .file_rdata, .ind_base,
    .tbl_rdata, .irq_entry, .dec, .file_we, .file_waddr, .file_wdata, .tbl_addr, .tbl_rd,
    .tbl_wr, .tbl_wdata, .flush
  );
  core_mem_model far (
    .aclk, .fetch_word, .file_we, .file_waddr, .file_wdata, .tbl_addr, .tbl_rd,
    .file_rdata, .tbl_rdata
  );
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic dn;
    dn = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        dn = 1'b1;
        chk(s_axi_bresp, er);
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic dn;
    dn = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        dn = 1'b1;
        chk(s_axi_rdata, ex);
        chk(s_axi_rresp, er);
      end
    end
  endtask : rd
  // one word per call; done closes the burst and lands on the result cycle
  task automatic fe(input logic [15:0] w, input fmt_e f);
    fetch_valid <= 1'b1;
    fetch_word <= w;
    fetch_format <= f;
    @(posedge aclk);
  endtask : fe
  task automatic done;
    fetch_valid <= 1'b0;
    @(posedge aclk);
  endtask : done
  task automatic t_regs;
    for (int a = 0; a < 5; a++) begin
      rd(8'(a * 4), 32'h0, `RESP_OKAY);
    end
    rd(`REG_INFO, 32'h1, `RESP_OKAY);
    wr(`REG_TPTR, 32'hFFFF_FFFF, `RESP_OKAY);
    rd(`REG_TPTR, 32'h001F_FFFF, `RESP_OKAY);
    wr(8'h18, 32'h1, `RESP_SLVERR);
    rd(8'h18, 32'h0, `RESP_SLVERR);
    wr(`REG_INFO, 32'h2, `RESP_SLVERR);
  endtask : t_regs
  task automatic t_byte;
    wr(`REG_WACC, 32'h05, `RESP_OKAY);
    wr(`REG_BANK, 32'h2, `RESP_OKAY);
    fe(16'h2690, FMT_BYTE);
    done;
    chk(file_we, 1'b1);
    chk(file_waddr, 12'hF90);
    chk(file_wdata, 8'h95);
    fe(16'h25FB, FMT_BYTE);
    done;
    chk(file_we, 1'b0);
    chk(dec.src_addr, 12'h2FB);
    rd(`REG_WACC, 32'h0, `RESP_OKAY);
    rd(`REG_STAT, 32'h07, `RESP_OKAY);
    alu_op <= ALU_SUB;
    fe(16'h2480, FMT_BYTE);
    done;
    rd(`REG_STAT, 32'h13, `RESP_OKAY);
  endtask : t_byte
  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      fe({4'h8, 3'(b), 9'h020}, FMT_BIT);
      done;
      chk(dec.bit_index, 32'(b));
      chk(dec.bit_mask, 32'h1 << b);
    end
  endtask : t_bits
  task automatic t_double;
    fe(16'hC123, FMT_MOVFF);
    fe(16'hFABC, FMT_NONE);
    done;
    chk(dec.src_addr, 12'h123);
    chk(dec.dst_addr, 12'hABC);
    fe(16'hEE25, FMT_LFSR);
    fe(16'hF0C3, FMT_NONE);
    done;
    chk(dec.ptr_sel, 2'h2);
    chk(dec.literal, 20'h005C3);
    ind_base <= 12'h100;
    fe(16'h0085, FMT_IDX);
    fe(16'hF0FF, FMT_NONE);
    done;
    chk(dec.src_addr, 12'h105);
    chk(dec.dst_addr, 12'h17F);
    fe(16'hF123, FMT_BYTE);
    done;
    chk(dec.valid, 1'b0);
    chk(file_we, 1'b0);
  endtask : t_double
  task automatic t_jump;
    fe(16'hEF34, FMT_GOTO);
    fe(16'hF567, FMT_NONE);
    done;
    chk(dec.branch, 21'h056734);
    chk(dec.rel, 1'b0);
    chk(flush, 1'b1);
    fe(16'hD400, FMT_BRA11);
    done;
    chk(dec.branch, 21'h1FFC00);
    chk(dec.rel, 1'b1);
    fe(16'h0E7F, FMT_LIT8);
    done;
    chk(dec.literal, 20'h0007F);
    fe(16'hE2F0, FMT_BRA8);
    done;
    chk(dec.branch, 21'h1FFFF0);
  endtask : t_jump
  // the pointer starts at its top value so post-increment wraps to zero
  task automatic t_table;
    logic [20:0] tp;
    logic [7:0] lat;
    logic [1:0] md [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    tp = 21'h1FFFFF;
    wr(`REG_TPTR, 32'h001F_FFFF, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      if (md[i] == 2'h3) tp = tp + 21'h1;
      fe({14'h0, md[i]}, FMT_TBL);
      done;
      chk(tbl_rd, 1'b1);
      chk(tbl_addr, tp);
      lat = tp[7:0] ^ 8'hA5;
      if (md[i] == 2'h1) tp = tp + 21'h1;
      if (md[i] == 2'h2) tp = tp - 21'h1;
      rd(`REG_TPTR, {11'h0, tp}, `RESP_OKAY);
      rd(`REG_TLAT, {24'h0, lat}, `RESP_OKAY);
    end
    fe(16'h0004, FMT_TBL);
    done;
    chk(tbl_wr, 1'b1);
    chk(tbl_wdata, lat);
  endtask : t_table
  task automatic t_fast;
    wr(`REG_WACC, 32'h11, `RESP_OKAY);
    wr(`REG_BANK, 32'h3, `RESP_OKAY);
    wr(`REG_STAT, 32'h0A, `RESP_OKAY);
    fe(16'hED34, FMT_CALL);
    fe(16'hF000, FMT_NONE);
    done;
    chk(dec.fast, 1'b1);
    wr(`REG_WACC, 32'h22, `RESP_OKAY);
    wr(`REG_BANK, 32'h5, `RESP_OKAY);
    wr(`REG_STAT, 32'h00, `RESP_OKAY);
    fe(16'h0012, FMT_RET);
    done;
    rd(`REG_WACC, 32'h22, `RESP_OKAY);
    fe(16'h0013, FMT_RET);
    done;
    rd(`REG_WACC, 32'h11, `RESP_OKAY);
    rd(`REG_BANK, 32'h3, `RESP_OKAY);
    rd(`REG_STAT, 32'h0A, `RESP_OKAY);
    wr(`REG_WACC, 32'h33, `RESP_OKAY);
    irq_entry <= 1'b1;
    @(posedge aclk);
    irq_entry <= 1'b0;
    wr(`REG_WACC, 32'h44, `RESP_OKAY);
    fe(16'h0013, FMT_RET);
    done;
    rd(`REG_WACC, 32'h33, `RESP_OKAY);
  endtask : t_fast
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // hang guard: the sequence needs well under two thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude;
    end
  end
  // reset, then the scenarios in turn
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {fetch_valid, irq_entry, fetch_word, ind_base} = 30'h0;
    fetch_format = FMT_NONE;
    alu_op = ALU_ADD;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_byte;
    t_bits;
    t_double;
    t_jump;
    t_table;
    t_fast;
    conclude;
  end
endmodule : operand_field_decoder_tb_top
